// *** core/cdd_divider.sv ***
// Purpose: two cascaded channel dividers with optional duty-cycle correction
// Assumes: hclk is the channel input clock (prescaler output or external clock)
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Notes on behaviour
// - raw duty is last stage high-plus-one ratio
// - both bypassed with prescaler passes prescaler duty
// - no prescaler, both bypassed passes input duty
// - correction on gives fifty percent output for even totals, unless both bypassed
// - odd total adds input duty half cycle
// - odd cascade duty follows half-cycle extension
// - count fields hold cycles minus one
// - channel ratio is product of stage ratios
// - correction on after reset until disabled
`timescale 1ns/1ns
module cdd_divider (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic clk_out
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] stage_div(input logic byp, input logic [3:0] n,
                                           input logic [3:0] m);
    stage_div = byp ? 6'h01 : ({2'b00, n} + {2'b00, m} + cdd_pkg::STAGE_DIV_ADD);
  endfunction : stage_div

  function automatic logic [31:0] stage_word(input logic byp, input logic [3:0] m,
                                             input logic [3:0] n);
    stage_word = {23'h000000, byp, m, n};
  endfunction : stage_word

  // ****************************************
  // register bus
  // ****************************************
  logic [3:0] n1_q, m1_q, n2_q, m2_q;
  logic byp1_q, byp2_q;
  logic corr_off_q, pre_used_q;
  logic [7:0] waddr_q;
  logic wr_q;
  logic [31:0] rdata_q;
  logic wave_q;

  wire logic take = hsel && hready && (htrans == cdd_pkg::HTRANS_NONSEQ ||
                                        htrans == cdd_pkg::HTRANS_SEQ);
  wire logic wr_stage1 = wr_q && waddr_q == cdd_pkg::STAGE1_OFF;
  wire logic wr_stage2 = wr_q && waddr_q == cdd_pkg::STAGE2_OFF;
  wire logic wr_ctrl = wr_q && waddr_q == cdd_pkg::CTRL_OFF;

  wire logic [5:0] div1 = stage_div(byp1_q, n1_q, m1_q);
  wire logic [5:0] div2 = stage_div(byp2_q, n2_q, m2_q);
  wire logic [10:0] ratio = 11'({5'h00, div1} * {5'h00, div2});
  wire logic both_byp = byp1_q && byp2_q;

  wire logic [31:0] rd_mux =
    (haddr == cdd_pkg::STAGE1_OFF) ? stage_word(byp1_q, m1_q, n1_q) :
    (haddr == cdd_pkg::STAGE2_OFF) ? stage_word(byp2_q, m2_q, n2_q) :
    (haddr == cdd_pkg::CTRL_OFF) ? {30'h0, pre_used_q, corr_off_q} :
    (haddr == cdd_pkg::STATUS_OFF) ? {19'h0, wave_q, 1'b0, ratio} : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      wr_q <= take && hwrite;
      waddr_q <= take ? haddr : waddr_q;
      rdata_q <= (take && !hwrite) ? rd_mux : rdata_q;
    end
  end

  // unmapped writes are dropped; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n1_q <= cdd_pkg::COUNT_RST;
      m1_q <= cdd_pkg::COUNT_RST;
      byp1_q <= cdd_pkg::BYPASS_RST;
      n2_q <= cdd_pkg::COUNT_RST;
      m2_q <= cdd_pkg::COUNT_RST;
      byp2_q <= cdd_pkg::BYPASS_RST;
      corr_off_q <= cdd_pkg::CORR_DISABLE_RST;
      pre_used_q <= cdd_pkg::PRESCALER_USED_RST;
    end else begin
      if (wr_stage1) begin
        n1_q <= hwdata[cdd_pkg::HIGH_LSB +: 4];
        m1_q <= hwdata[cdd_pkg::LOW_LSB +: 4];
        byp1_q <= hwdata[cdd_pkg::BYPASS_BIT];
      end
      if (wr_stage2) begin
        n2_q <= hwdata[cdd_pkg::HIGH_LSB +: 4];
        m2_q <= hwdata[cdd_pkg::LOW_LSB +: 4];
        byp2_q <= hwdata[cdd_pkg::BYPASS_BIT];
      end
      if (wr_ctrl) begin
        corr_off_q <= hwdata[cdd_pkg::CORR_DISABLE_BIT];
        pre_used_q <= hwdata[cdd_pkg::PRESCALER_USED_BIT];
      end
    end
  end

  // ****************************************
  // cascaded counters
  // ****************************************
  logic [4:0] c1_q, c2_q;
  // counters wrap on >= so a smaller ratio written mid-period recovers at once
  wire logic tick1 = ({1'b0, c1_q} >= div1 - 6'h01);
  wire logic wrap2 = ({1'b0, c2_q} >= div2 - 6'h01);
  wire logic [4:0] c1_d = tick1 ? 5'h00 : c1_q + 5'h01;
  wire logic [4:0] c2_d = tick1 ? (wrap2 ? 5'h00 : c2_q + 5'h01) : c2_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1_q <= 5'h00;
      c2_q <= 5'h00;
    end else begin
      c1_q <= c1_d;
      c2_q <= c2_d;
    end
  end

  // ****************************************
  // waveform and correction
  // ****************************************
  // position within the whole channel period, for the corrected waveform
  wire logic [9:0] pos_d = 10'({5'h00, c2_d} * {4'h0, div1} + {5'h00, c1_d});
  wire logic stage2_on = !byp2_q;
  // raw: high for the first high-count-plus-one cycles of the last active stage
  wire logic raw_d = stage2_on ? (c2_d <= {1'b0, n2_q}) : (c1_d <= {1'b0, n1_q});
  // 2*pos+1 < P keeps the high part at (P-1)/2 cycles for an odd P; the stretch adds the half
  wire logic corr_d = ({pos_d, 1'b1} < ratio);
  wire logic wave_d = corr_off_q ? raw_d : corr_d;
  wire logic odd_total = ratio[0] && !corr_off_q && !both_byp;
  logic ext_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  // falling-edge copy stretches the high phase by half an input cycle,
  // so an odd total gives 50% from a 50% input and (P-1)/2+X otherwise
  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= wave_q;
    end
  end

  // both stages bypassed: the input clock itself (prescaler output or
  // external clock) goes straight out, so its own duty is kept
  assign clk_out = both_byp ? hclk : (wave_q | (ext_q & odd_total));

  // ****************************************
  // check helpers
  // ****************************************
  // the count checks only look once the setting has been left alone for
  // two channel periods, because a write may leave one odd period behind
  logic [11:0] quiet_q;
  logic [9:0] hi_cnt_q;
  logic [10:0] per_cnt_q;
  logic wave_prev_q;
  wire logic [11:0] quiet_d = wr_q ? 12'h000 : (quiet_q == 12'hfff) ? quiet_q :
                              quiet_q + 12'h001;
  wire logic settled = (quiet_q > ({ratio, 1'b0} + 12'h004));
  // previous level resets to the reset level of wave_q, so no false rise
  wire logic rise = wave_q && !wave_prev_q;
  wire logic [9:0] hi_cnt_d = wave_q ? hi_cnt_q + 10'h001 : 10'h000;
  wire logic [10:0] per_cnt_d = rise ? 11'h001 :
                                (per_cnt_q == 11'h7ff) ? per_cnt_q : per_cnt_q + 11'h001;
  // expected raw high time in input cycles: high count plus one of the last
  // active stage, each of its steps lasting one first-stage period
  wire logic [9:0] raw_hi_exp = byp2_q ? ({6'h00, n1_q} + 10'h001) :
                                (({6'h00, n2_q} + 10'h001) * {4'h0, div1});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_q <= 12'h000;
      hi_cnt_q <= 10'h000;
      per_cnt_q <= 11'h000;
      wave_prev_q <= 1'b0;
    end else begin
      quiet_q <= quiet_d;
      hi_cnt_q <= hi_cnt_d;
      per_cnt_q <= per_cnt_d;
      wave_prev_q <= wave_q;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_ratio_product: assert property (@(posedge hclk) disable iff (!hresetn)
    ratio == (byp1_q ? 11'h1 : 11'({2'b00, n1_q} + {2'b00, m1_q} + 6'h2)) *
             (byp2_q ? 11'h1 : 11'({2'b00, n2_q} + {2'b00, m2_q} + 6'h2)))
    else $error("channel ratio is not the product of stage ratios");

  chk_stage1_range: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(wr_q) == 1'b0 && !wr_q) |-> ({1'b0, c1_q} < div1))
    else $error("first stage count left its range");

  chk_stage2_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (c2_q != $past(c2_q)) |-> $past(tick1))
    else $error("second stage moved without a first stage period");

  chk_raw_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (corr_off_q && stage2_on && c2_d == 5'h00 && !wr_q) |=> wave_q)
    else $error("raw output not high at start of period");

  chk_raw_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (corr_off_q && stage2_on && c2_d > {1'b0, n2_q} && !wr_q) |=> !wave_q)
    else $error("raw output high past the high count");

  chk_corr_half: assert property (@(posedge hclk) disable iff (!hresetn)
    (!corr_off_q && !wr_q) |=> (wave_q == ({$past(pos_d), 1'b1} < $past(ratio))))
    else $error("corrected output not high for the first half period");

  // the stretch lives between a rising and the next falling edge, so only
  // falling-edge sampling can see it
  chk_odd_stretch: assert property (@(negedge hclk) disable iff (!hresetn)
    ($fell(wave_q) && odd_total && $stable(ratio)) |-> (ext_q && clk_out))
    else $error("odd period not stretched by half a cycle");

  chk_stretch_end: assert property (@(negedge hclk) disable iff (!hresetn)
    (!wave_q && !$past(wave_q) && !both_byp) |-> !clk_out)
    else $error("stretch lasted longer than half a cycle");

  chk_corr_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (corr_off_q != $past(corr_off_q)) |-> $past(wr_ctrl))
    else $error("correction setting changed without a control write");

  chk_bypass_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(both_byp) && both_byp) |-> (ratio == 11'h1 && c1_q == 5'h00 && c2_q == 5'h00))
    else $error("bypassed channel is not divide by one");

  // whole-period counts, held against the rules rather than the counters
  chk_corr_count: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(wave_q) && !corr_off_q && !both_byp && settled) |-> (hi_cnt_q == ratio[10:1]))
    else $error("corrected high time is not half the channel period");

  chk_raw_count: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(wave_q) && corr_off_q && !both_byp && settled) |-> (hi_cnt_q == raw_hi_exp))
    else $error("raw high time is not the high count of the last stage");

  chk_output_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise && !both_byp && settled) |-> (per_cnt_q == ratio))
    else $error("output period is not the channel ratio");

  chk_stage2_range: assert property (@(posedge hclk) disable iff (!hresetn)
    settled |-> ({1'b0, c2_q} < div2))
    else $error("second stage count left its range");

  // register bus side
  chk_stage1_fields: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_stage1 |=> (n1_q == $past(hwdata[cdd_pkg::HIGH_LSB +: 4]) &&
                   m1_q == $past(hwdata[cdd_pkg::LOW_LSB +: 4]) &&
                   byp1_q == $past(hwdata[cdd_pkg::BYPASS_BIT])))
    else $error("first stage write did not land in its fields");

  chk_stage2_fields: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_stage2 |=> (n2_q == $past(hwdata[cdd_pkg::HIGH_LSB +: 4]) &&
                   m2_q == $past(hwdata[cdd_pkg::LOW_LSB +: 4]) &&
                   byp2_q == $past(hwdata[cdd_pkg::BYPASS_BIT])))
    else $error("second stage write did not land in its fields");

  chk_ctrl_fields: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> (corr_off_q == $past(hwdata[cdd_pkg::CORR_DISABLE_BIT]) &&
                 pre_used_q == $past(hwdata[cdd_pkg::PRESCALER_USED_BIT])))
    else $error("control write did not land in its fields");

  // read data must stand until the next read is taken
  chk_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(take && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

endmodule : cdd_divider

// *** include/cdd_pkg.sv ***
// Purpose: constants for the cascaded channel divider with duty-cycle correction
// Assumes: AHB-Lite register access, 32-bit data, one aligned word per register
// Notes: stage count fields hold cycles minus one
package cdd_pkg;
  // register byte offsets
  localparam logic [7:0] STAGE1_OFF = 8'h00;
  localparam logic [7:0] STAGE2_OFF = 8'h04;
  localparam logic [7:0] CTRL_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  // stage register fields
  localparam int HIGH_LSB = 0;
  localparam int LOW_LSB = 4;
  localparam int BYPASS_BIT = 8;
  // control register fields
  localparam int CORR_DISABLE_BIT = 0;
  localparam int PRESCALER_USED_BIT = 1;
  // status register fields
  localparam int RATIO_LSB = 0;
  localparam int LEVEL_BIT = 12;
  // values after reset
  localparam logic [3:0] COUNT_RST = 4'h0;
  localparam logic BYPASS_RST = 1'b0;
  localparam logic CORR_DISABLE_RST = 1'b0;
  localparam logic PRESCALER_USED_RST = 1'b0;
  // stage division is high field plus low field plus this
  localparam logic [5:0] STAGE_DIV_ADD = 6'h02;
  // ahb codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : cdd_pkg

// *** tb/test_cdd_divider.sv ***
// Purpose: self-checking bench for the cascaded divider with duty-cycle correction
// Assumes: one AHB-Lite slave, hready tied to hreadyout, 50% duty on hclk
// Notes: duty is measured from clk_out edge times in ns
`timescale 1ns/1ns
module test_cdd_divider;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, clk_out;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  int error_cnt = 0;
  int comparisons = 0;

  cdd_divider DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clk_out(clk_out));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task conclude;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // called just after a rising edge; returns at the edge that ends the data phase
  task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= cdd_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb_xfer

  function automatic logic [31:0] stg(input logic b, input logic [3:0] m, input logic [3:0] n);
    return {23'h0, b, m, n};
  endfunction : stg

  // high time and period of clk_out, after the new setting has settled
  task measure(input logic [31:0] hi, input logic [31:0] per);
    realtime t0, t1, t2;
    repeat (3) @(posedge clk_out);
    t0 = $realtime;
    @(negedge clk_out);
    t1 = $realtime;
    @(posedge clk_out);
    t2 = $realtime;
    chk(32'(int'(t1 - t0)), hi);
    chk(32'(int'(t2 - t0)), per);
    @(posedge hclk);
  endtask : measure

  task run_case(input logic [31:0] s1, s2, ctl, ratio, hi, per);
    ahb_xfer(1'b1, cdd_pkg::STAGE1_OFF, s1);
    ahb_xfer(1'b1, cdd_pkg::STAGE2_OFF, s2);
    ahb_xfer(1'b1, cdd_pkg::CTRL_OFF, ctl);
    ahb_xfer(1'b0, cdd_pkg::STATUS_OFF, 32'h0);
    chk({21'h0, rd[10:0]}, ratio);
    measure(hi, per);
  endtask : run_case

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb_xfer(1'b0, cdd_pkg::STAGE1_OFF, 32'h0);
    chk(rd, 32'h0);
    ahb_xfer(1'b0, cdd_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    ahb_xfer(1'b0, cdd_pkg::STATUS_OFF, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h4);
    measure(32'h14, 32'h28);
    ahb_xfer(1'b1, 8'h10, 32'hffffffff);
    ahb_xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    ahb_xfer(1'b1, cdd_pkg::CTRL_OFF, 32'h3);
    ahb_xfer(1'b0, cdd_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h3);
    // second stage bypassed, first stage carries the ratio
    run_case(stg(0, 4'h1, 4'h1), stg(1, 4'h0, 4'h0), 32'h2, 32'h4, 32'h14, 32'h28);
    run_case(stg(0, 4'h2, 4'h1), stg(1, 4'h0, 4'h0), 32'h3, 32'h5, 32'h14, 32'h32);
    run_case(stg(0, 4'h2, 4'h1), stg(1, 4'h0, 4'h0), 32'h2, 32'h5, 32'h19, 32'h32);
    run_case(stg(0, 4'h2, 4'h1), stg(1, 4'h0, 4'h0), 32'h1, 32'h5, 32'h14, 32'h32);
    // cascade: raw high time is counted in first-stage periods
    run_case(stg(0, 4'h1, 4'h0), stg(0, 4'h1, 4'h1), 32'h3, 32'hc, 32'h3c, 32'h78);
    run_case(stg(0, 4'h1, 4'h0), stg(0, 4'h1, 4'h1), 32'h2, 32'hc, 32'h3c, 32'h78);
    run_case(stg(0, 4'h1, 4'h0), stg(0, 4'h2, 4'h1), 32'h2, 32'hf, 32'h4b, 32'h96);
    run_case(stg(0, 4'h1, 4'h0), stg(0, 4'h2, 4'h1), 32'h3, 32'hf, 32'h3c, 32'h96);
    run_case(stg(0, 4'hf, 4'hf), stg(0, 4'hf, 4'hf), 32'h3, 32'h400, 32'h1400, 32'h2800);
    // both bypassed: the input clock passes through
    run_case(stg(1, 4'h0, 4'h0), stg(1, 4'h0, 4'h0), 32'h1, 32'h1, 32'h5, 32'ha);
    run_case(stg(1, 4'h0, 4'h0), stg(1, 4'h0, 4'h0), 32'h2, 32'h1, 32'h5, 32'ha);
    conclude();
  end

  // the longest case is about 45 us; allow a wide margin
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end
endmodule : test_cdd_divider
